//--- src/abs_pkg.sv
// package of constants and types for the autobaud serial block
// Notes on behaviour
// - timer unit serves capture or compare, one function at a time, switched at run time.
// - arm capture on falling receive edge (start bit) and store timestamp.
// - then rearm for rising edge and store its timestamp.
// - rising minus falling timestamp is the length of eight bit times.
// - bit period is that length shifted right by three.
// - half bit period is bit period shifted right by one.
// - compare mode raises one event per bit period (one and a half before the first receive sample); one bit moves per event.
// - transmit line idles high, driven low for each start bit.
// - eight data bits sent least significant first, one per bit period.
package abs_pkg;
	localparam int ABS_TIMER_W = 16;
	localparam int ABS_DATA_BITS = 8;
	localparam int ABS_PERIOD_SHIFT = 3;
	localparam int ABS_HALF_SHIFT = 1;
	localparam logic [3:0] ABS_BIT_CNT_RST = 4'h0;
	localparam logic [ABS_TIMER_W-1:0] ABS_TIMER_RST = 16'h0000;
	localparam logic ABS_LINE_IDLE = 1'b1;

	typedef enum logic [2:0] {
		ABS_CAL_FALL = 3'b000,
		ABS_CAL_RISE = 3'b001,
		ABS_IDLE = 3'b010,
		ABS_TX = 3'b011,
		ABS_RX_WAIT = 3'b100,
		ABS_RX = 3'b101
	} abs_state_e;
endpackage

//--- src/abs_cmp_if.sv
// interface between the sequencer and the capture/compare unit
`timescale 1ns/1ps
interface abs_cmp_if #(parameter int W = 16);
	logic cap_mode;
	logic cap_rise;
	logic arm;
	logic [W-1:0] interval;
	logic event_p;
	logic [W-1:0] stamp;
	modport ctl (output cap_mode, output cap_rise, output arm, output interval,
		input event_p, input stamp);
	modport unit (input cap_mode, input cap_rise, input arm, input interval,
		output event_p, output stamp);
endinterface

//--- src/abs_capture_compare_unit.sv
// free-running timer shared between edge capture and interval compare
`timescale 1ns/1ps
module abs_capture_compare_unit
	import abs_pkg::*;
#(
	parameter int W = ABS_TIMER_W
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// line and control
	input wire logic serial_in_line_i,
	abs_cmp_if.unit cu
);
	logic [W-1:0] timer;
	logic [W-1:0] target;
	logic line_q;
	logic event_p;
	logic [W-1:0] stamp;
	logic [W-1:0] next_timer;
	logic [W-1:0] next_target;
	logic next_event_p;
	logic [W-1:0] next_stamp;
	logic edge_hit;

	assign cu.event_p = event_p;
	assign cu.stamp = stamp;

	always_comb begin
		next_timer = W'(timer + 1'b1);
		next_target = target;
		next_stamp = stamp;
		next_event_p = 1'b0;
		edge_hit = cu.cap_rise ? (!line_q && serial_in_line_i) : (line_q && !serial_in_line_i);
		// one mode at a time: capture ignores the compare target and vice versa
		if (cu.cap_mode) begin
			if (edge_hit) begin
				next_stamp = timer;
				next_event_p = 1'b1;
			end
		end else if (cu.arm) begin
			next_target = W'(timer + cu.interval);
		end else if (timer == target) begin
			next_event_p = 1'b1;
			next_target = W'(timer + cu.interval);
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			timer <= W'(ABS_TIMER_RST);
			target <= W'(ABS_TIMER_RST);
			line_q <= ABS_LINE_IDLE;
			event_p <= 1'b0;
			stamp <= W'(ABS_TIMER_RST);
		end else begin
			timer <= next_timer;
			target <= next_target;
			line_q <= serial_in_line_i;
			event_p <= next_event_p;
			stamp <= next_stamp;
		end
	end
endmodule // abs_capture_compare_unit

//--- src/abs_autobaud_serial.sv
// autobaud serial sequencer: calibrates bit period, then sends and receives bytes
`timescale 1ns/1ps
module abs_autobaud_serial
	import abs_pkg::*;
#(
	parameter int W = ABS_TIMER_W
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// serial pins
	input wire logic serial_in_line_i,
	output logic serial_out_line_o,
	// transmit request
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	// receive result and status
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic calibrated_o,
	output logic [W-1:0] bit_period_o
);
	// the shifted measurement must fit the timer, and a narrow timer wraps within one frame
	if (W < 8 || W > 32) begin : g_bad_width
		$error("abs_autobaud_serial: W out of range");
	end

	abs_cmp_if #(.W(W)) cif ();

	abs_capture_compare_unit #(.W(W)) u_capture_compare_unit (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.serial_in_line_i(serial_in_line_i),
		.cu(cif)
	);

	abs_state_e state, next_state;
	logic [W-1:0] fall_stamp, next_fall_stamp;
	logic [W-1:0] bit_period, next_bit_period;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic tx_line, next_tx_line;
	logic rx_valid, next_rx_valid;
	logic [7:0] rx_data, next_rx_data;
	logic calibrated, next_calibrated;
	logic tx_ready, next_tx_ready;
	logic [W-1:0] eight_bits;
	logic line_q;
	logic start_fall;

	assign eight_bits = W'(cif.stamp - fall_stamp);

	assign serial_out_line_o = tx_line;
	assign tx_ready_o = tx_ready;
	assign rx_valid_o = rx_valid;
	assign rx_data_o = rx_data;
	assign calibrated_o = calibrated;
	assign bit_period_o = bit_period;

	// receive start is seen on the registered line so it matches the timer's view
	assign start_fall = line_q && !serial_in_line_i;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			line_q <= ABS_LINE_IDLE;
		end else begin
			line_q <= serial_in_line_i;
		end
	end

	always_comb begin
		next_state = state;
		next_fall_stamp = fall_stamp;
		next_bit_period = bit_period;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_tx_line = tx_line;
		next_rx_valid = 1'b0;
		next_rx_data = rx_data;
		next_calibrated = calibrated;
		cif.cap_mode = 1'b0;
		cif.cap_rise = 1'b0;
		cif.arm = 1'b0;
		cif.interval = bit_period;
		case (state)
			ABS_CAL_FALL: begin
				// the far side opens with the calibration character
				cif.cap_mode = 1'b1;
				if (cif.event_p) begin
					next_fall_stamp = cif.stamp;
					next_state = ABS_CAL_RISE;
				end
			end
			ABS_CAL_RISE: begin
				cif.cap_mode = 1'b1;
				cif.cap_rise = 1'b1;
				if (cif.event_p) begin
					next_bit_period = eight_bits >> ABS_PERIOD_SHIFT;
					next_calibrated = 1'b1;
					next_state = ABS_IDLE;
				end
			end
			ABS_IDLE: begin
				next_tx_line = ABS_LINE_IDLE;
				if (tx_valid_i && calibrated) begin
					next_tx_line = 1'b0;
					next_shreg = tx_data_i;
					next_bit_cnt = ABS_BIT_CNT_RST;
					cif.arm = 1'b1;
					next_state = ABS_TX;
				end else if (start_fall) begin
					// one and a half periods puts the first sample mid data bit
					cif.interval = W'(bit_period + (bit_period >> ABS_HALF_SHIFT));
					cif.arm = 1'b1;
					next_bit_cnt = ABS_BIT_CNT_RST;
					next_state = ABS_RX_WAIT;
				end
			end
			ABS_TX: begin
				if (cif.event_p) begin
					if (bit_cnt == 4'(ABS_DATA_BITS)) begin
						next_tx_line = 1'b1;
						next_state = ABS_IDLE;
					end else begin
						next_tx_line = shreg[0];
						next_shreg = {1'b0, shreg[7:1]};
						next_bit_cnt = 4'(bit_cnt + 1'b1);
					end
				end
			end
			ABS_RX_WAIT: begin
				// the first event comes after the long wait; then re-arm at one period
				if (cif.event_p) begin
					next_shreg = {serial_in_line_i, shreg[7:1]};
					next_bit_cnt = 4'h1;
					cif.arm = 1'b1;
					next_state = ABS_RX;
				end
			end
			ABS_RX: begin
				if (cif.event_p) begin
					next_shreg = {serial_in_line_i, shreg[7:1]};
					next_bit_cnt = 4'(bit_cnt + 1'b1);
					if (bit_cnt == 4'(ABS_DATA_BITS - 1)) begin
						next_rx_data = {serial_in_line_i, shreg[7:1]};
						next_rx_valid = 1'b1;
						// idle waits for a fresh falling edge, so the stop bit is skipped
						next_state = ABS_IDLE;
					end
				end
			end
			default: begin
				next_state = ABS_CAL_FALL;
			end
		endcase
		// ready is decoded from the next state so the pin comes straight from a flop
		next_tx_ready = (next_state == ABS_IDLE) && next_calibrated;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ABS_CAL_FALL;
			fall_stamp <= W'(ABS_TIMER_RST);
			bit_period <= W'(ABS_TIMER_RST);
			bit_cnt <= ABS_BIT_CNT_RST;
			shreg <= 8'h00;
			tx_line <= ABS_LINE_IDLE;
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
			calibrated <= 1'b0;
			tx_ready <= 1'b0;
		end else begin
			state <= next_state;
			fall_stamp <= next_fall_stamp;
			bit_period <= next_bit_period;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			tx_line <= next_tx_line;
			rx_valid <= next_rx_valid;
			rx_data <= next_rx_data;
			calibrated <= next_calibrated;
			tx_ready <= next_tx_ready;
		end
	end

	a_idle_line_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_IDLE && $past(state) == ABS_IDLE) |-> serial_out_line_o)
		else $error("tx line not high while idle");

	a_start_bit_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_IDLE && tx_valid_i && calibrated) |=> !serial_out_line_o)
		else $error("start bit not low");

	a_period_shift: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_CAL_RISE && cif.event_p) |=>
		bit_period == $past(W'(cif.stamp - fall_stamp)) >> 3)
		else $error("bit period not eighth of measured span");

	a_one_mode_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		cif.cap_mode |-> !cif.arm && (state == ABS_CAL_FALL || state == ABS_CAL_RISE))
		else $error("capture active outside calibration");

	a_rise_after_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_CAL_FALL && cif.event_p) |=> state == ABS_CAL_RISE && cif.cap_rise)
		else $error("capture not rearmed for rising edge");

	a_fall_stored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_CAL_FALL && cif.event_p) |=> fall_stamp == $past(cif.stamp))
		else $error("falling stamp not stored");

	a_tx_bit_value: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_TX && cif.event_p && bit_cnt < 4'h8) |=>
		serial_out_line_o == $past(shreg[0]))
		else $error("tx bit not lsb of shift register");

	a_stop_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_TX && cif.event_p && bit_cnt == 4'h8) |=>
		serial_out_line_o && state == ABS_IDLE)
		else $error("stop bit missing");

	a_rx_done: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_RX && cif.event_p && bit_cnt == 4'h7) |=>
		rx_valid_o && rx_data_o[7] == $past(serial_in_line_i))
		else $error("received byte not delivered");

	a_event_one_bit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state == ABS_RX && !cif.event_p) |=> bit_cnt == $past(bit_cnt))
		else $error("bit moved without compare event");
endmodule // abs_autobaud_serial

//--- test/abs_remote_serial.sv
// behavioural model of the remote serial transmitter and receiver
`timescale 1ns/1ps
module abs_remote_serial (
	// clock
	input wire logic clk_sys_i,
	// serial lines seen from the far end
	input wire logic serial_out_line_i,
	output logic serial_in_line_o
);
	initial serial_in_line_o = 1'b1;

	// start bit, eight data bits lsb first, stop bit; 8'h80 is the calibration character
	task automatic send_frame(input int p, input logic [7:0] d);
		@(posedge clk_sys_i);
		serial_in_line_o <= 1'b0;
		repeat (p) @(posedge clk_sys_i);
		for (int i = 0; i < 8; i++) begin
			serial_in_line_o <= d[i];
			repeat (p) @(posedge clk_sys_i);
		end
		serial_in_line_o <= 1'b1;
		repeat (p) @(posedge clk_sys_i);
	endtask

	// samples mid-bit; the stop bit is two cycles long between back-to-back bytes
	task automatic recv_frame(input int p, output logic [8:0] got);
		int k;
		got = 9'h000;
		for (k = 0; k < 40 * p && serial_out_line_i !== 1'b0; k++) @(posedge clk_sys_i);
		repeat (p + p / 2) @(posedge clk_sys_i);
		for (int i = 0; i < 8; i++) begin
			got[i] = serial_out_line_i;
			if (i < 7) repeat (p) @(posedge clk_sys_i);
		end
		// first cycle of the stop bit, so a high last data bit cannot stand in for it
		repeat (p / 2 + 1) @(posedge clk_sys_i);
		got[8] = serial_out_line_i;
	endtask
endmodule // abs_remote_serial

//--- test/tb_top.sv
// self-checking bench for the autobaud serial block
`timescale 1ns/1ps
module tb_top;
	import abs_pkg::*;
	localparam int P = 16;
	localparam int P2 = 24;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic serial_in_line;
	logic serial_out_line;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_ready;
	logic rx_valid;
	logic [7:0] rx_data;
	logic [7:0] rx_last = 8'h00;
	logic calibrated;
	logic [ABS_TIMER_W-1:0] bit_period;
	int err_count = 0;
	int cmp_count = 0;
	int rx_pulses = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	abs_autobaud_serial #(.W(ABS_TIMER_W)) i_abs_autobaud_serial (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .serial_in_line_i(serial_in_line),
		.serial_out_line_o(serial_out_line), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
		.calibrated_o(calibrated), .bit_period_o(bit_period));

	abs_remote_serial i_abs_remote_serial (.clk_sys_i(clk_sys_i),
		.serial_out_line_i(serial_out_line), .serial_in_line_o(serial_in_line));

	// counting pulses shows a pulse that lasts two cycles
	always @(posedge clk_sys_i) if (rx_valid === 1'b1) begin
		rx_pulses <= rx_pulses + 1;
		rx_last <= rx_data;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// let an edge pass first so a second call never sees the ready of the byte just taken
	task automatic send_tx(input logic [7:0] d);
		@(posedge clk_sys_i);
		for (int k = 0; k < 20 * P && tx_ready !== 1'b1; k++) @(posedge clk_sys_i);
		check(tx_ready, 1, "never ready for send");
		tx_valid <= 1'b1;
		tx_data <= d;
		@(posedge clk_sys_i);
		tx_valid <= 1'b0;
	endtask

	// requests before calibration must be ignored
	task automatic test_reset();
		check(serial_out_line, 1, "line not idle high");
		check(tx_ready, 0, "ready before calibration");
		tx_valid <= 1'b1;
		tx_data <= 8'h00;
		repeat (4) begin
			@(posedge clk_sys_i);
			check(serial_out_line, 1, "send before calibration");
		end
		tx_valid <= 1'b0;
		$display("test_reset done");
	endtask

	task automatic test_cal();
		i_abs_remote_serial.send_frame(P, 8'h80);
		repeat (3) @(posedge clk_sys_i);
		check(calibrated, 1, "not calibrated");
		check(bit_period, P, "bit period");
		$display("test_cal done");
	endtask

	// back-to-back bytes with a two-cycle stop bit between them
	task automatic test_tx();
		logic [8:0] g1;
		logic [8:0] g2;
		fork
			begin
				send_tx(8'ha5);
				send_tx(8'h3c);
			end
			begin
				i_abs_remote_serial.recv_frame(P, g1);
				i_abs_remote_serial.recv_frame(P, g2);
			end
		join
		check(g1, 9'h1a5, "first byte sent");
		check(g2, 9'h13c, "second byte sent");
		repeat (P + 2) @(posedge clk_sys_i);
		check(serial_out_line, 1, "line not idle after stop");
		$display("test_tx done");
	endtask

	task automatic test_rx();
		logic [7:0] d [2] = '{8'h5a, 8'h81};
		for (int i = 0; i < 2; i++) begin
			i_abs_remote_serial.send_frame(P, d[i]);
			check(rx_pulses, i + 1, "receive pulse count");
			check(rx_last, d[i], "received byte");
		end
		$display("test_rx done");
	endtask

	// a reset in mid-run drops the rate; a new calibration at another rate must follow
	task automatic test_recal();
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		check(calibrated, 0, "calibration kept over reset");
		check(bit_period, 0, "period kept over reset");
		check(tx_ready, 0, "ready kept over reset");
		i_abs_remote_serial.send_frame(P2, 8'h80);
		repeat (3) @(posedge clk_sys_i);
		check(calibrated, 1, "not calibrated again");
		check(bit_period, P2, "second bit period");
		i_abs_remote_serial.send_frame(P2, 8'hc3);
		check(rx_last, 8'hc3, "byte at second rate");
		$display("test_recal done");
	endtask

	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		test_reset();
		test_cal();
		test_tx();
		test_rx();
		test_recal();
		report_and_stop();
	end

	// whole run needs under 200 bit periods
	initial begin
		repeat (400 * P) @(posedge clk_sys_i);
		err_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		report_and_stop();
	end
endmodule // tb_top
